//--- bsos_cfg.svh
// Timing, code and reset constants of the buck start-up sequencer.
`ifndef BSOS_CFG_SVH
`define BSOS_CFG_SVH

`define BSOS_CLK_NS 10
`define BSOS_SS_TIME_NS 6800000
`define BSOS_SS_STEPS 64
`define BSOS_SS_STEP_CYC (`BSOS_SS_TIME_NS / `BSOS_CLK_NS / `BSOS_SS_STEPS)
`define BSOS_SS_LAST 6'h3f
`define BSOS_SMP_TIME_NS 3400000
`define BSOS_SMP_CODES 256
`define BSOS_SMP_STEP_CYC (`BSOS_SMP_TIME_NS / `BSOS_CLK_NS / `BSOS_SMP_CODES)
`define BSOS_BLANK_NS 200
`define BSOS_BLANK_CYC ((`BSOS_BLANK_NS + `BSOS_CLK_NS - 1) / `BSOS_CLK_NS)
`define BSOS_MINW_NS 425
`define BSOS_MINW_CYC ((`BSOS_MINW_NS + `BSOS_CLK_NS - 1) / `BSOS_CLK_NS)
`define BSOS_NARROW_LAST 2'h2
`define BSOS_DUMMY_LAST 1'h1
`define BSOS_OCP_LIMIT_CODE 8'h96
`define BSOS_SET_RST 8'h00
`define BSOS_SYNC_RST 3'h0

`endif

//--- bsos_pkg.sv
// Types shared by the buck start-up sequencer.
package bsos_pkg;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_WAITEN = 3'b001,
    ST_DELAY  = 3'b010,
    ST_SAMPLE = 3'b011,
    ST_INIT   = 3'b100,
    ST_RAMP   = 3'b101,
    ST_RUN    = 3'b110,
    ST_HICCUP = 3'b111
  } bsos_state_t;

endpackage

//--- bsos_sequencer.sv
// Start-up, soft-start and overcurrent sequencer of a synchronous buck controller.
//
// Function
// - Start initialization once the bias supply exceeds its power-on threshold.
// - With enable held low at power-up, wait until enable rises.
// - Pull enable up internally; timing starts only at threshold crossing.
// - Wait a fixed delay after enable crossing before sampling.
// - During the delay keep low gate off and drive the sense current.
// - Sample the set point over a variable interval, longer for higher settings.
// - Hold the sampled set point in a counter driving a DAC.
// - Start soft-start right after sampling ends.
// - Ramp the reference from zero to final over the soft-start period.
// - Ramp in 64 equal fixed steps, same for both frequency versions.
// - Enable error amplifier after a short init; flag done at ramp end.
// - Output pre-biased low: switches off until ramp passes output.
// - Output pre-biased high: switches off until soft-start ends.
// - Disable then release after soft-start reruns the full initialization.
// - Overcurrent retries reuse the stored set point without resampling.
// - On a trip shut off, two dummy timeouts, one real attempt, repeat.
// - Set point persists while powered; replaced only by a post-shutdown sample.
// - Monitor low switch from blanking time after low gate rises until it falls.
// - Three narrow or missing low pulses: stretch or insert the third one.
// - With protection disabled, pulse stretching is disabled too.
// - Trip when switch voltage exceeds twice the sampled set-point voltage.
// - Enable pulled low stops oscillator, holds gates low, re-arms soft-start.
// - Set point above the limit or no resistor disables protection.
`include "bsos_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module bsos_sequencer #(
  parameter int unsigned STEP_CYC = `BSOS_SS_STEP_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic bias_ok_a,
  input wire logic en_above_a,
  input wire logic setpt_above_a,
  input wire logic oc_cmp_a,
  input wire logic vout_above_a,
  input wire logic pwm_high_req,
  input wire logic pwm_low_req,
  input wire logic cycle_start,
  output logic high_side_gate,
  output logic low_side_gate,
  output logic sense_current_on,
  output logic en_pullup_on,
  output logic osc_run,
  output logic ea_enable,
  output logic softstart_done,
  output logic hiccup_active,
  output logic ocp_disabled,
  output logic [5:0] ss_ref_code,
  output logic [7:0] trip_set_code,
  output logic [8:0] trip_ref_code
);
  localparam int NSYNC = 5;
  localparam logic [19:0] STEP_LAST = 20'(STEP_CYC - 1);
  localparam logic [19:0] SMP_LAST = 20'(`BSOS_SMP_STEP_CYC - 1);
  localparam logic [5:0] BLANK = 6'(`BSOS_BLANK_CYC);
  localparam logic [5:0] MINW = 6'(`BSOS_MINW_CYC);
  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync_q;
  logic bias_s;
  logic en_s;
  logic setpt_s;
  logic oc_s;
  logic vout_s;
  assign async_in = {vout_above_a, oc_cmp_a, setpt_above_a, en_above_a, bias_ok_a};
  assign bias_s = sync_q[0];
  assign en_s = sync_q[1];
  assign setpt_s = sync_q[2];
  assign oc_s = sync_q[3];
  assign vout_s = sync_q[4];
  // Each pin passes three flops; the value moves only when stages two and three agree.
  generate
    for (genvar gi = 0; gi < NSYNC; gi++) begin : g_sync
      logic [2:0] ff_r;
      logic q_r;
      always_ff @(posedge mclk) begin
        if (rst) begin
          ff_r <= `BSOS_SYNC_RST;
          q_r <= 1'b0;
        end else begin
          ff_r <= {ff_r[1:0], async_in[gi]};
          if (ff_r[1] == ff_r[2]) begin
            q_r <= ff_r[2];
          end
        end
      end
      assign sync_q[gi] = q_r;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state and shared timebase.
  bsos_pkg::bsos_state_t st_r;
  bsos_pkg::bsos_state_t st_nxt;
  logic [19:0] tick_cnt_r;
  logic [5:0] step_r;
  logic dummy_r;
  logic tick;
  logic step_end;
  logic trip;
  logic smp_done;
  logic [7:0] set_r;
  logic ocp_off_r;
  assign tick = (tick_cnt_r == 20'h00000);
  assign step_end = tick && (step_r == `BSOS_SS_LAST);
  // Sampling ends once the DAC reaches the pin level or reaches the limit.
  assign smp_done = tick && (!setpt_s || (set_r == `BSOS_OCP_LIMIT_CODE));
  // Next state; loss of bias or enable overrides every other transition.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      bsos_pkg::ST_OFF: begin
        if (bias_s) begin
          st_nxt = bsos_pkg::ST_WAITEN;
        end
      end
      bsos_pkg::ST_WAITEN: begin
        if (en_s) begin
          st_nxt = bsos_pkg::ST_DELAY;
        end
      end
      bsos_pkg::ST_DELAY: begin
        if (step_end) begin
          st_nxt = bsos_pkg::ST_SAMPLE;
        end
      end
      bsos_pkg::ST_SAMPLE: begin
        if (smp_done) begin
          st_nxt = bsos_pkg::ST_INIT;
        end
      end
      bsos_pkg::ST_INIT: begin
        if (tick) begin
          st_nxt = bsos_pkg::ST_RAMP;
        end
      end
      bsos_pkg::ST_RAMP: begin
        if (trip) begin
          st_nxt = bsos_pkg::ST_HICCUP;
        end else if (step_end) begin
          st_nxt = bsos_pkg::ST_RUN;
        end
      end
      bsos_pkg::ST_RUN: begin
        if (trip) begin
          st_nxt = bsos_pkg::ST_HICCUP;
        end
      end
      bsos_pkg::ST_HICCUP: begin
        if (step_end && dummy_r == `BSOS_DUMMY_LAST) begin
          st_nxt = bsos_pkg::ST_INIT;
        end
      end
      default: begin
        st_nxt = bsos_pkg::ST_OFF;
      end
    endcase
    if (!bias_s) begin
      st_nxt = bsos_pkg::ST_OFF;
    end else if (!en_s && st_r != bsos_pkg::ST_OFF) begin
      st_nxt = bsos_pkg::ST_WAITEN;
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= bsos_pkg::ST_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // One down-counter paces delay, sample, init, ramp and dummy steps.
  always_ff @(posedge mclk) begin
    if (rst) begin
      tick_cnt_r <= STEP_LAST;
    end else if (st_nxt != st_r || tick) begin
      tick_cnt_r <= (st_nxt == bsos_pkg::ST_SAMPLE) ? SMP_LAST : STEP_LAST;
    end else begin
      tick_cnt_r <= tick_cnt_r - 20'h00001;
    end
  end

  // Step index of the 64-step delay, dummy timeout and ramp.
  always_ff @(posedge mclk) begin
    if (rst) begin
      step_r <= 6'h00;
    end else if (st_nxt != st_r) begin
      step_r <= 6'h00;
    end else if (tick) begin
      step_r <= step_r + 6'h01;
    end
  end

  // Counts dummy timeouts within a retry.
  always_ff @(posedge mclk) begin
    if (rst) begin
      dummy_r <= 1'b0;
    end else if (st_r != bsos_pkg::ST_HICCUP) begin
      dummy_r <= 1'b0;
    end else if (step_end) begin
      dummy_r <= ~dummy_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Set-point sample and hold.
  // The code climbs one step per sample tick; only a fresh sample replaces it.
  always_ff @(posedge mclk) begin
    if (rst) begin
      set_r <= `BSOS_SET_RST;
      ocp_off_r <= 1'b0;
    end else if (st_r == bsos_pkg::ST_DELAY) begin
      set_r <= `BSOS_SET_RST;
    end else if (st_r == bsos_pkg::ST_SAMPLE && tick) begin
      if (!setpt_s) begin
        ocp_off_r <= 1'b0;
      end else if (set_r == `BSOS_OCP_LIMIT_CODE) begin
        ocp_off_r <= 1'b1;
      end else begin
        set_r <= set_r + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Low-side monitoring, pulse stretching and gate drive.
  logic drive;
  logic gates_ok_r;
  logic [5:0] blank_r;
  logic [5:0] width_r;
  logic [5:0] force_r;
  logic [1:0] narrow_r;
  logic forcing;
  logic low_nxt;
  logic high_nxt;
  assign drive = gates_ok_r && (st_r == bsos_pkg::ST_RAMP || st_r == bsos_pkg::ST_RUN);
  assign forcing = (force_r != 6'h00);
  assign low_nxt = drive && (pwm_low_req || forcing);
  assign high_nxt = drive && pwm_high_req && !forcing;
  // Trip only inside the window after blanking while the low gate stays high.
  assign trip = !ocp_off_r && low_side_gate && (blank_r >= BLANK) && oc_s;
  // Switches stay off until the ramp passes a low pre-bias, or ramp end.
  always_ff @(posedge mclk) begin
    if (rst) begin
      gates_ok_r <= 1'b0;
    end else if (st_r == bsos_pkg::ST_RUN) begin
      gates_ok_r <= 1'b1;
    end else if (st_r != bsos_pkg::ST_RAMP) begin
      gates_ok_r <= 1'b0;
    end else if (!vout_s) begin
      gates_ok_r <= 1'b1;
    end
  end

  // Blanking counter runs while the low gate is high.
  always_ff @(posedge mclk) begin
    if (rst) begin
      blank_r <= 6'h00;
    end else if (!low_side_gate) begin
      blank_r <= 6'h00;
    end else if (blank_r < BLANK) begin
      blank_r <= blank_r + 6'h01;
    end
  end

  // Width of the low pulse within the current switching cycle.
  always_ff @(posedge mclk) begin
    if (rst) begin
      width_r <= 6'h00;
    end else if (cycle_start) begin
      width_r <= 6'h00;
    end else if (low_side_gate && width_r < MINW) begin
      width_r <= width_r + 6'h01;
    end
  end

  // Third narrow cycle in a row gets a forced low pulse of minimum width.
  always_ff @(posedge mclk) begin
    if (rst) begin
      narrow_r <= 2'h0;
      force_r <= 6'h00;
    end else if (!drive || ocp_off_r) begin
      narrow_r <= 2'h0;
      force_r <= 6'h00;
    end else if (cycle_start) begin
      // The gate cycle that ends at the boundary has not been counted yet.
      if (width_r >= MINW || (low_side_gate && width_r == MINW - 6'h01)) begin
        narrow_r <= 2'h0;
      end else if (narrow_r == `BSOS_NARROW_LAST) begin
        narrow_r <= 2'h0;
        force_r <= MINW;
      end else begin
        narrow_r <= narrow_r + 2'h1;
      end
    end else if (forcing) begin
      force_r <= force_r - 6'h01;
    end
  end

  // Gate outputs; both low whenever the sequencer is not driving.
  always_ff @(posedge mclk) begin
    if (rst) begin
      high_side_gate <= 1'b0;
      low_side_gate <= 1'b0;
    end else begin
      high_side_gate <= high_nxt && !trip;
      low_side_gate <= low_nxt && !trip;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status and analog control outputs.
  // Registered controls for the analog side.
  always_ff @(posedge mclk) begin
    if (rst) begin
      sense_current_on <= 1'b0;
      en_pullup_on <= 1'b0;
      osc_run <= 1'b0;
      ea_enable <= 1'b0;
      softstart_done <= 1'b0;
      hiccup_active <= 1'b0;
      ocp_disabled <= 1'b0;
    end else begin
      sense_current_on <= (st_nxt == bsos_pkg::ST_DELAY) ||
                          (st_nxt == bsos_pkg::ST_SAMPLE);
      en_pullup_on <= (st_nxt != bsos_pkg::ST_OFF);
      osc_run <= (st_nxt != bsos_pkg::ST_OFF) && (st_nxt != bsos_pkg::ST_WAITEN);
      ea_enable <= (st_nxt == bsos_pkg::ST_RAMP) || (st_nxt == bsos_pkg::ST_RUN);
      softstart_done <= (st_nxt == bsos_pkg::ST_RUN);
      hiccup_active <= (st_nxt == bsos_pkg::ST_HICCUP);
      ocp_disabled <= ocp_off_r;
    end
  end

  // Reference code follows the ramp step and holds full scale when running.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ss_ref_code <= 6'h00;
    end else if (st_r == bsos_pkg::ST_RUN) begin
      ss_ref_code <= `BSOS_SS_LAST;
    end else if (st_r == bsos_pkg::ST_RAMP) begin
      ss_ref_code <= step_r;
    end else begin
      ss_ref_code <= 6'h00;
    end
  end

  // Set-point DAC and the doubled trip reference.
  always_ff @(posedge mclk) begin
    if (rst) begin
      trip_set_code <= `BSOS_SET_RST;
      trip_ref_code <= 9'h000;
    end else begin
      trip_set_code <= set_r;
      trip_ref_code <= {set_r, 1'b0};
    end
  end
endmodule // bsos_sequencer

`default_nettype wire

//--- bsos_sequencer_chk.sv
// Port-level assertions of the buck start-up sequencer.
`timescale 1ns/1ps
`default_nettype none
module bsos_sequencer_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic en_above_a,
  input wire logic high_side_gate,
  input wire logic low_side_gate,
  input wire logic sense_current_on,
  input wire logic en_pullup_on,
  input wire logic ea_enable,
  input wire logic softstart_done,
  input wire logic hiccup_active,
  input wire logic ocp_disabled,
  input wire logic [5:0] ss_ref_code,
  input wire logic [7:0] trip_set_code,
  input wire logic [8:0] trip_ref_code
);
  logic [7:0] lg_cnt_r;
  ////////////////////////////////////////////////////////////////////////////////
  // Counts how many cycles the low gate has been high, saturating at the top.
  always_ff @(posedge mclk) begin
    if (rst || !low_side_gate) lg_cnt_r <= 8'h00;
    else if (lg_cnt_r != 8'hff) lg_cnt_r <= lg_cnt_r + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // All checks share the one clock and its reset.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_en_low;
    !en_above_a [*7];
  endsequence
  sequence s_gates_off;
    !high_side_gate && !low_side_gate;
  endsequence
  property p_sense_off;
    sense_current_on |-> s_gates_off;
  endproperty
  a_sense_off: assert property (p_sense_off) else $error("gate on while sensing");
  property p_pullup;
    sense_current_on |-> en_pullup_on;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up off while sensing");
  property p_pair;
    $stable(trip_set_code) |-> trip_ref_code == {trip_set_code, 1'b0};
  endproperty
  a_pair: assert property (p_pair) else $error("trip reference not doubled");
  property p_done;
    softstart_done |-> ea_enable && ss_ref_code == 6'h3f;
  endproperty
  a_done: assert property (p_done) else $error("done before ramp top");
  property p_hold;
    hiccup_active |=> $stable(trip_set_code);
  endproperty
  a_hold: assert property (p_hold) else $error("set point moved in retry");
  property p_step;
    ea_enable && $past(ea_enable) && !$stable(ss_ref_code)
      |-> ss_ref_code == $past(ss_ref_code) + 6'h01;
  endproperty
  a_step: assert property (p_step) else $error("ramp step not one code");
  property p_en_low;
    s_en_low |-> s_gates_off;
  endproperty
  a_en_low: assert property (p_en_low) else $error("gates on while disabled");
  property p_hic_off;
    hiccup_active |-> s_gates_off;
  endproperty
  a_hic_off: assert property (p_hic_off) else $error("gates on in retry");
  // The gate count one cycle before the retry flag rises is the blanking count at the trip.
  property p_blank;
    $rose(hiccup_active) |-> $past(lg_cnt_r) >= 8'h14;
  endproperty
  a_blank: assert property (p_blank) else $error("trip inside blanking");
  property p_ocp_off;
    ocp_disabled && !hiccup_active |=> !hiccup_active;
  endproperty
  a_ocp_off: assert property (p_ocp_off) else $error("trip while guard off");
endmodule // bsos_sequencer_chk
bind bsos_sequencer bsos_sequencer_chk u_chk (.mclk(mclk), .rst(rst), .en_above_a(en_above_a),
  .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
  .sense_current_on(sense_current_on), .en_pullup_on(en_pullup_on), .ea_enable(ea_enable),
  .softstart_done(softstart_done), .hiccup_active(hiccup_active),
  .ocp_disabled(ocp_disabled), .ss_ref_code(ss_ref_code), .trip_set_code(trip_set_code),
  .trip_ref_code(trip_ref_code));
`default_nettype wire

//--- bsos_partner.sv
// Model of the power switches, output filter and set-point resistor.
`timescale 1ns/1ps
`default_nettype none
module bsos_partner (
  input wire logic mclk,
  input wire logic high_side_gate,
  input wire logic low_side_gate,
  input wire logic sense_current_on,
  input wire logic [5:0] ss_ref_code,
  input wire logic [7:0] trip_set_code,
  input wire logic [8:0] trip_ref_code,
  input wire logic shorted,
  input wire logic [7:0] res_code,
  input wire logic [7:0] pre_lvl,
  input wire logic pre_load,
  output logic setpt_above_a,
  output logic oc_cmp_a,
  output logic vout_above_a
);
  logic [7:0] vout_r;
  logic tog_r = 1'b0;
  logic [8:0] sw_lvl;
  // Output holds its charge until switching, then follows the reference; a short empties it.
  always_ff @(posedge mclk) begin
    tog_r <= ~tog_r;
    if (pre_load) vout_r <= pre_lvl;
    else if (shorted) vout_r <= 8'h00;
    else if (high_side_gate || low_side_gate) vout_r <= {2'h0, ss_ref_code};
  end
  // An unsensed set-point pin toggles so that no stale level looks valid.
  assign setpt_above_a = sense_current_on ? (res_code > trip_set_code) : tog_r;
  assign sw_lvl = shorted ? 9'h1ff : 9'h000;
  assign oc_cmp_a = low_side_gate ? (sw_lvl > trip_ref_code) : high_side_gate;
  // Equal levels count as not yet passed, so the ramp must exceed the output.
  assign vout_above_a = vout_r >= {2'h0, ss_ref_code};
endmodule // bsos_partner
`default_nettype wire

//--- bsos_sequencer_tb.sv
// Self-checking bench of the buck start-up sequencer.
`timescale 1ns/1ps
`default_nettype none
module bsos_sequencer_tb;
  localparam int STEP = 8;
  logic mclk, rst, bias_ok_a, en_above_a, pwm_high_req, pwm_low_req, cycle_start;
  logic setpt_above_a, oc_cmp_a, vout_above_a, high_side_gate, low_side_gate;
  logic sense_current_on, en_pullup_on, osc_run, ea_enable, softstart_done;
  logic hiccup_active, ocp_disabled, shorted, pre_load, pwm_full, pre_bad;
  logic [5:0] ss_ref_code;
  logic [7:0] trip_set_code, res_code, pre_lvl;
  logic [8:0] trip_ref_code;
  int num_errors = 0, cmp_count = 0, duty = 40, ph = 0, n;
  int exp_q[$];
  int set_exp = 0;
  bsos_sequencer #(.STEP_CYC(STEP)) u_bsos_sequencer (.mclk(mclk), .rst(rst),
    .bias_ok_a(bias_ok_a), .en_above_a(en_above_a), .setpt_above_a(setpt_above_a),
    .oc_cmp_a(oc_cmp_a), .vout_above_a(vout_above_a), .pwm_high_req(pwm_high_req),
    .pwm_low_req(pwm_low_req), .cycle_start(cycle_start), .high_side_gate(high_side_gate),
    .low_side_gate(low_side_gate), .sense_current_on(sense_current_on),
    .en_pullup_on(en_pullup_on), .osc_run(osc_run), .ea_enable(ea_enable),
    .softstart_done(softstart_done), .hiccup_active(hiccup_active),
    .ocp_disabled(ocp_disabled), .ss_ref_code(ss_ref_code), .trip_set_code(trip_set_code),
    .trip_ref_code(trip_ref_code));
  bsos_partner u_bsos_partner (.mclk(mclk), .high_side_gate(high_side_gate),
    .low_side_gate(low_side_gate), .sense_current_on(sense_current_on),
    .ss_ref_code(ss_ref_code), .trip_set_code(trip_set_code), .trip_ref_code(trip_ref_code),
    .shorted(shorted), .res_code(res_code), .pre_lvl(pre_lvl), .pre_load(pre_load),
    .setpt_above_a(setpt_above_a), .oc_cmp_a(oc_cmp_a), .vout_above_a(vout_above_a));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and a 100-cycle internal PWM with optional full high duty.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    #1;
    ph = (ph == 99) ? 0 : ph + 1;
    cycle_start = (ph == 0);
    pwm_high_req = pwm_full || (ph < duty);
    pwm_low_req = !pwm_full && (ph >= duty);
  end
  // Flags switching in the ramp while the reference is not yet above the output.
  always @(posedge mclk) begin
    if (ea_enable && !softstart_done && (high_side_gate || low_side_gate)
        && {2'h0, ss_ref_code} <= pre_lvl) pre_bad <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, comparisons and bounded waits.
  task automatic stop_test;
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp_code(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_code({15'h0, got}, {15'h0, exp});
  endtask
  task automatic cmp_cnt(input int got, input int exp);
    cmp_code(16'(got), 16'(exp));
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return sense_current_on;
      1: return ea_enable;
      2: return softstart_done;
      3: return hiccup_active;
      default: return low_side_gate;
    endcase
  endfunction
  task automatic wait_for(input int s, input logic v, output int cnt);
    cnt = 0;
    while (sig(s) !== v) begin
      @(posedge mclk);
      #1;
      cnt++;
      if (cnt > 60000) begin
        num_errors++;
        stop_test();
      end
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  // Releases enable and follows one start-up against the model's expectations.
  task automatic bring_up(input int r);
    int e;
    exp_q.push_back(r > 150 ? 150 : r);
    res_code = 8'(r);
    pre_bad = 1'b0;
    en_above_a = 1'b1;
    wait_for(0, 1'b1, n);
    wait_for(0, 1'b0, n);
    e = exp_q.pop_front();
    set_exp = e;
    cmp_code(16'(trip_set_code), 16'(e));
    cmp_code(16'(trip_ref_code), 16'(2 * e));
    cmp_bit(ocp_disabled, 1'b0);
    wait_for(1, 1'b1, n);
    cmp_cnt(n, STEP);
    wait_for(2, 1'b1, n);
    cmp_cnt(n, 64 * STEP);
    cmp_code(16'(ss_ref_code), 16'h003f);
    cmp_bit(osc_run, 1'b1);
    cmp_bit(pre_bad, 1'b0);
    wait_for(4, 1'b1, n);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {rst, bias_ok_a, en_above_a, pwm_high_req, pwm_low_req, cycle_start} = 6'h20;
    {shorted, pre_load, pwm_full, pre_bad} = 4'h4;
    res_code = 8'h00;
    pre_lvl = 8'h14;
    void'($urandom(5630));
    step(6);
    rst = 1'b0;
    pre_load = 1'b0;
    step(10);
    cmp_bit(en_pullup_on, 1'b0);
    bias_ok_a = 1'b1;
    step(40);
    cmp_bit(en_pullup_on, 1'b1);
    cmp_bit(sense_current_on, 1'b0);
    duty = 20 + $urandom % 40;
    bring_up(4 + $urandom % 8);
    pwm_full = 1'b1;
    wait_for(4, 1'b0, n);
    wait_for(4, 1'b1, n);
    wait_for(4, 1'b0, n);
    cmp_cnt(n, 43);
    pwm_full = 1'b0;
    en_above_a = 1'b0;
    step(10);
    cmp_bit(high_side_gate, 1'b0);
    cmp_bit(softstart_done, 1'b0);
    cmp_bit(osc_run, 1'b0);
    pre_lvl = 8'h5a;
    pre_load = 1'b1;
    step(2);
    pre_load = 1'b0;
    bring_up(2 + $urandom % 4);
    shorted = 1'b1;
    wait_for(3, 1'b1, n);
    cmp_bit(low_side_gate, 1'b0);
    wait_for(3, 1'b0, n);
    cmp_cnt(n, 128 * STEP);
    wait_for(3, 1'b1, n);
    cmp_code(16'(trip_ref_code), {7'h0, trip_set_code, 1'b0});
    cmp_code(16'(trip_set_code), 16'(set_exp));
    shorted = 1'b0;
    wait_for(3, 1'b0, n);
    wait_for(2, 1'b1, n);
    cmp_bit(softstart_done, 1'b1);
    bias_ok_a = 1'b0;
    step(10);
    cmp_bit(en_pullup_on, 1'b0);
    stop_test();
  end
endmodule // bsos_sequencer_tb
`default_nettype wire
